// >>> verilog/status_pkg.sv
// Constants for the driver status readout block.
// Assumes a 16-bit register word with the invalid flag at bit 1 and parity
// at bit 0.
package status_pkg;
  localparam int WORD_W = 16;
  localparam int PAR_BIT = 0;
  localparam int INVALID_BIT = 1;
  localparam int CNT_LSB = 8;
  localparam int CNT_MSB = 15;
  localparam int CNT_W = 8;
  localparam int VERS_LSB = 4;
  localparam int VERS_MSB = 15;
  localparam int VERS_W = 12;
  localparam int DEBUG_BIT = 10;
  localparam int PWM_BIT = 4;
  localparam logic [1:0] VSEL_CLOCK_SUP = 2'h2;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Register selectors, a local index for this block only
  localparam logic [1:0] SEL_CLOCK_SUP = 2'h0;
  localparam logic [1:0] SEL_IDENT = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_SPARE = 2'h3;
  // Arbitrary neutral version value
  localparam logic [11:0] SECONDARY_VERSION_DEFAULT = 12'h123;
endpackage

// >>> verilog/sync2.sv
// Two-flop synchroniser for a single level.
// Assumes the destination clock is the block clock.
`timescale 1ns/10ps
module sync2
  import status_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// >>> verilog/driver_status_readout.sv
// Read-only status words: clock supervision, identity, secondary status.
// Assumes SPI framing logic on the same clock supplies select, read strobe
// and the last-message verdict; oscillator and status levels are async.
`timescale 1ns/10ps
// Overview of operation
// - Bit 1 reports whether last message discarded
// - Bit 0 makes every word odd parity
// - Supervision counts oscillator cycles into 15:8
// - Only the clear-count bit or reset clears the count
// - Bits 15:4 of ident hold fixed version
// - Status bit 10 shows debug mode
// - Status bit 4 shows last PWM command
// - Supervision runs only select 10 in mode
module driver_status_readout
  import status_pkg::*;
#(
  parameter logic [11:0] SECONDARY_VERSION = SECONDARY_VERSION_DEFAULT
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_sel,
  input wire logic msg_done,
  input wire logic msg_discarded,
  input wire logic clear_count_bit,
  input wire logic [1:0] verification_select,
  input wire logic verification_op_mode,
  input wire logic primary_oscillator,
  input wire logic debug_mode,
  input wire logic pwm_on_cmd,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [7:0] clock_cycle_count,
  output logic last_msg_invalid
);
  logic osc_s;
  logic debug_s;
  logic pwm_s;
  logic osc_prev_reg;
  logic [7:0] count_reg;
  logic invalid_reg;
  logic sup_active;
  logic osc_rise;
  logic [15:0] word_next;

  sync2 u_osc (.clock(clock), .arst_n(arst_n), .din(primary_oscillator),
    .dout(osc_s));
  sync2 u_debug (.clock(clock), .arst_n(arst_n), .din(debug_mode),
    .dout(debug_s));
  sync2 u_pwm (.clock(clock), .arst_n(arst_n), .din(pwm_on_cmd),
    .dout(pwm_s));

  // Oscillator must run well below half the block clock to be counted
  assign sup_active = (verification_select == VSEL_CLOCK_SUP) &&
    verification_op_mode;
  assign osc_rise = osc_s && !osc_prev_reg;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      osc_prev_reg <= 1'b0;
    else
      osc_prev_reg <= osc_s;
  end

  // Count saturates so a long window does not wrap to a low value
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      count_reg <= CNT_ZERO;
    else if (clear_count_bit)
      count_reg <= CNT_ZERO;
    else if (sup_active && osc_rise && (count_reg != CNT_MAX))
      count_reg <= count_reg + CNT_ONE;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      invalid_reg <= 1'b0;
    else if (msg_done)
      invalid_reg <= msg_discarded;
  end

  always_comb
  begin
    word_next = WORD_ZERO;
    unique case (rd_sel)
      SEL_CLOCK_SUP: word_next[CNT_MSB:CNT_LSB] = count_reg;
      SEL_IDENT: word_next[VERS_MSB:VERS_LSB] = SECONDARY_VERSION;
      SEL_STATUS:
      begin
        word_next[DEBUG_BIT] = debug_s;
        word_next[PWM_BIT] = pwm_s;
      end
      default: word_next = WORD_ZERO;
    endcase
    word_next[INVALID_BIT] = invalid_reg;
    word_next[PAR_BIT] = ~(^word_next[WORD_W-1:1]);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= WORD_ZERO;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_strobe;
      if (rd_strobe)
        rd_data <= word_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clock_cycle_count <= CNT_ZERO;
      last_msg_invalid <= 1'b0;
    end
    else
    begin
      clock_cycle_count <= count_reg;
      last_msg_invalid <= invalid_reg;
    end
  end

  a_word_parity: assert property (@(posedge clock) disable iff (!arst_n)
    rd_valid |-> (^rd_data) == 1'b1)
    else $error("read word parity not odd");
  a_invalid_bit: assert property (@(posedge clock) disable iff (!arst_n)
    rd_valid |-> rd_data[INVALID_BIT] == $past(invalid_reg))
    else $error("invalid flag bit wrong");
  a_count_clear: assert property (@(posedge clock) disable iff (!arst_n)
    clear_count_bit |=> count_reg == CNT_ZERO)
    else $error("count not cleared");
  a_count_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !sup_active && !clear_count_bit |=> $stable(count_reg))
    else $error("count moved while inactive");
  a_count_step: assert property (@(posedge clock) disable iff (!arst_n)
    sup_active && osc_rise && !clear_count_bit && count_reg != CNT_MAX
    |=> count_reg == $past(count_reg) + CNT_ONE)
    else $error("count not incremented");
  a_ident_fixed: assert property (@(posedge clock) disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_IDENT
    |=> rd_data[VERS_MSB:VERS_LSB] == SECONDARY_VERSION
    && rd_data[3:2] == 2'h0)
    else $error("ident word wrong");
  a_status_bits: assert property (@(posedge clock) disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_STATUS
    |=> rd_data[DEBUG_BIT] == $past(debug_s)
    && rd_data[PWM_BIT] == $past(pwm_s)
    && rd_data[15:11] == 5'h0)
    else $error("status bits wrong");
  a_sup_reserved: assert property (@(posedge clock) disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_CLOCK_SUP |=> rd_data[7:2] == 6'h0)
    else $error("reserved bits not zero");

  // Observed count output lags the counter by exactly one cycle
  a_count_copy: assert property (@(posedge clock)
    disable iff (!arst_n) 1'b1 |=> clock_cycle_count == $past(count_reg))
    else $error("count copy stale");

  a_invalid_copy: assert property (@(posedge clock)
    disable iff (!arst_n)
    1'b1 |=> last_msg_invalid == $past(invalid_reg))
    else $error("invalid flag copy stale");

  // Each finished message replaces the verdict, good or bad
  a_invalid_update: assert property (@(posedge clock)
    disable iff (!arst_n)
    msg_done |=> invalid_reg == $past(msg_discarded))
    else $error("invalid flag not updated");

  a_invalid_hold: assert property (@(posedge clock)
    disable iff (!arst_n) !msg_done |=> $stable(invalid_reg))
    else $error("invalid flag moved without message");

  // One answer per request, never a stray one
  a_valid_pulse: assert property (@(posedge clock)
    disable iff (!arst_n) 1'b1 |=> rd_valid == $past(rd_strobe))
    else $error("read answer not one cycle after request");

  // Host may sample the word late, so it must not change between reads
  a_data_hold: assert property (@(posedge clock)
    disable iff (!arst_n) !rd_strobe |=> $stable(rd_data))
    else $error("read word changed without request");

  // Saturation keeps a long window from reading back as a short one
  a_count_sat: assert property (@(posedge clock)
    disable iff (!arst_n)
    count_reg == CNT_MAX && !clear_count_bit |=> count_reg == CNT_MAX)
    else $error("count wrapped");

  a_sup_field: assert property (@(posedge clock)
    disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_CLOCK_SUP
    |=> rd_data[CNT_MSB:CNT_LSB] == $past(count_reg))
    else $error("count field wrong");

  a_spare_zero: assert property (@(posedge clock)
    disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_SPARE |=> rd_data[15:2] == 14'h0)
    else $error("spare word not zero");

  // Reserved status bits are read-only here, so they must stay clear
  a_status_rsvd: assert property (@(posedge clock)
    disable iff (!arst_n)
    rd_strobe && rd_sel == SEL_STATUS
    |=> rd_data[9:5] == 5'h0 && rd_data[3:2] == 2'h0)
    else $error("status reserved bits not zero");

  a_count_reset_free: assert property (@(posedge clock)
    disable iff (!arst_n)
    !clear_count_bit && !(sup_active && osc_rise) |=> $stable(count_reg))
    else $error("count changed without cause");
endmodule

// >>> sim/host_model.sv
// Host side of the read port: read strobes and message verdicts.
// Assumes the block samples everything on the rising clock edge.
`timescale 1ns/10ps
module host_model
(
  input wire logic clock,
  output logic rd_strobe,
  output logic [1:0] rd_sel,
  output logic msg_done,
  output logic msg_discarded
);
  initial
  begin
    rd_strobe = 1'b0;
    rd_sel = 2'h0;
    msg_done = 1'b0;
    msg_discarded = 1'b0;
  end
  // Released lines flip so a stale value is never read as valid
  task automatic rd(input logic [1:0] s);
    @(posedge clock);
    rd_strobe <= 1'b1;
    rd_sel <= s;
    @(posedge clock);
    rd_strobe <= 1'b0;
    rd_sel <= ~s;
  endtask
  task automatic msg(input logic bad);
    @(posedge clock);
    msg_done <= 1'b1;
    msg_discarded <= bad;
    @(posedge clock);
    msg_done <= 1'b0;
    msg_discarded <= ~bad;
  endtask
endmodule

// >>> sim/tb_driver_status_readout.sv
// Bench for the status readout: reads each word and checks it.
// Assumes host_model drives reads; async levels come from here.
`timescale 1ns/10ps
module tb_driver_status_readout
  import status_pkg::*;
;
  logic clock, arst_n, clr, osc, debug_lvl, pwm, op;
  logic stb, done, bad, valid, invalid_flag;
  logic [1:0] vsel, sel;
  logic [15:0] data, e;
  logic [7:0] cnt;
  logic [15:0] q[$];
  int err_total = 0;
  int num_checks = 0;
  int n;
  host_model i_host (.clock(clock), .rd_strobe(stb), .rd_sel(sel),
    .msg_done(done), .msg_discarded(bad));
  driver_status_readout i_dut (.clock(clock), .arst_n(arst_n),
    .rd_strobe(stb), .rd_sel(sel), .msg_done(done),
    .msg_discarded(bad), .clear_count_bit(clr),
    .verification_select(vsel), .verification_op_mode(op),
    .primary_oscillator(osc), .debug_mode(debug_lvl), .pwm_on_cmd(pwm),
    .rd_data(data), .rd_valid(valid), .clock_cycle_count(cnt),
    .last_msg_invalid(invalid_flag));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic rd(input logic [1:0] s, input logic [15:0] d);
    q.push_back({d[15:1], ~^d[15:1]});
    i_host.rd(s);
  endtask
  // Slow edges so the two-flop sampler sees every one
  task automatic pulses(input int k);
    repeat (k)
    begin
      repeat (4) @(posedge clock);
      osc <= 1'b1;
      repeat (4) @(posedge clock);
      osc <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock)
  begin
    if (valid === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 16'hXXXX;
      num_checks++;
      if (data !== e)
      begin
        err_total++;
        $display("ERROR t=%0t got %h exp %h", $time, data, e);
      end
    end
  end
  initial
  begin
    arst_n = 1'b0;
    clr = 1'b0;
    osc = 1'b0;
    debug_lvl = 1'b0;
    pwm = 1'b0;
    op = 1'b0;
    vsel = 2'h0;
    void'($urandom(97237));
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    rd(SEL_IDENT, {SECONDARY_VERSION_DEFAULT, 4'h0});
    i_host.msg(1'b1);
    rd(2'h3, 16'h0002);
    chk({15'h0000, invalid_flag}, 16'h0001);
    i_host.msg(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      debug_lvl <= i[0];
      pwm <= i[1];
      repeat (4) @(posedge clock);
      rd(SEL_STATUS, {5'h0, i[0], 5'h0, i[1], 4'h0});
    end
    chk({15'h0000, invalid_flag}, 16'h0000);
    n = $urandom_range(9, 2);
    for (int j = 0; j < 3; j++)
    begin
      vsel <= (j == 0) ? 2'h1 : VSEL_CLOCK_SUP;
      op <= (j != 1);
      pulses(n);
      rd(SEL_CLOCK_SUP, (j == 2) ? {n[7:0], 8'h00} : WORD_ZERO);
    end
    chk({8'h00, cnt}, {8'h00, n[7:0]});
    clr <= 1'b1;
    repeat (2) @(posedge clock);
    clr <= 1'b0;
    repeat (2) @(posedge clock);
    rd(SEL_CLOCK_SUP, WORD_ZERO);
    chk({8'h00, cnt}, WORD_ZERO);
    repeat (4) @(posedge clock);
    if (q.size() != 0)
      err_total++;
    complete_run();
  end
endmodule
